// file: core/relay_switch_ctrl.sv
// Command handler, relay driver and query responder of one cascaded switcher unit
`timescale 1ns/1ns
`default_nettype none
module relay_switch_ctrl #(
  parameter int         CLK_HZ      = relay_switch_pkg::CLK_HZ,
  parameter int         BAUD        = relay_switch_pkg::BAUD_RATE,
  parameter int         BIT_CYCLES  = CLK_HZ / BAUD,
  parameter int         GAP_CYCLES  = BIT_CYCLES * relay_switch_pkg::GAP_BITS,
  parameter logic [7:0] FW_VERSION  = 8'h01,   // Arbitrary value
  parameter logic [7:0] HW_STATUS   = 8'h02    // Arbitrary value
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] addr_sw_i,      // Rear coding switch
  input  wire logic       out_type_i,     // 1 output switcher, 0 input switcher
  input  wire logic       up_rx_i,        // Commands from the previous unit
  output logic            down_tx_o,      // Commands to the next unit
  input  wire logic       down_reply_i,   // Replies from the next unit
  output logic            up_reply_o,     // Replies to the previous unit
  output logic [7:0]      relay_a_o,      // Busbar A relays
  output logic [7:0]      relay_b_o,      // Busbar B relays
  output logic [7:0]      led_chan_a_o,   // Green channel indicators
  output logic [7:0]      led_chan_b_o,   // Yellow channel indicators
  output logic            led_bus_a_o,
  output logic            led_bus_b_o,
  output logic            led_power_o,
  output logic            cmd_drop_o      // Pulse: malformed command discarded
);
  localparam int TCW = $clog2(BIT_CYCLES) + 1;
  localparam int GCW = $clog2(GAP_CYCLES) + 1;
  localparam logic [TCW-1:0] TX_FULL = TCW'(BIT_CYCLES - 1);
  localparam logic [GCW-1:0] GAP_MAX = GCW'(GAP_CYCLES - 1);
  localparam logic [1:0]     RESP_LAST = 2'(relay_switch_pkg::RESP_LEN - 1);

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_st_t;

  logic [7:0] rx_data;
  logic       rx_valid, rx_err;

  // Byte receiver on the upstream line
  serial_byte_rx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_rx (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .rx_i    (up_rx_i),
    .data_o  (rx_data),
    .valid_o (rx_valid),
    .err_o   (rx_err)
  );

  // Decode a channel number to this unit's one-hot relay pattern
  function automatic logic [7:0] chan_hot(input logic [7:0] chan, input logic [3:0] addr);
    logic [7:0] base;
    logic [7:0] idx;
    base = 8'({addr, 3'b000});
    idx  = chan - base - 8'h01;
    chan_hot = 8'h00;
    if (chan != relay_switch_pkg::CHAN_NONE && idx < 8'(relay_switch_pkg::CH_PER_UNIT)) begin
      chan_hot[idx[2:0]] = 1'b1;
    end
  endfunction

  // Command parser state
  logic [1:0]     pos_r, pos_nxt;       // Byte position in the frame
  logic [7:0]     hdr_r, hdr_nxt;
  logic [7:0]     arg_r, arg_nxt;
  logic [GCW-1:0] gap_r, gap_nxt;       // Inter-byte silence
  logic [7:0]     rly_a_r, rly_a_nxt;
  logic [7:0]     rly_b_r, rly_b_nxt;
  logic [7:0]     chan_a_r, chan_a_nxt; // Last busbar A channel, kept for minus one
  logic           drop_nxt;
  logic           query_hit, set_fire, set_all_b, frame_ok, type_ok;
  logic           ready_r, fwd_r;
  logic [3:0]     op;
  logic           is_b;

  assign op   = hdr_r[relay_switch_pkg::OP_MSB:relay_switch_pkg::OP_LSB];
  assign is_b = hdr_r[relay_switch_pkg::BUS_BIT];

  // Parser next state; a frame is header, argument, check byte
  always_comb begin
    pos_nxt    = pos_r;
    hdr_nxt    = hdr_r;
    arg_nxt    = arg_r;
    gap_nxt    = gap_r;
    rly_a_nxt  = rly_a_r;
    rly_b_nxt  = rly_b_r;
    chan_a_nxt = chan_a_r;
    drop_nxt   = 1'b0;
    query_hit  = 1'b0;
    set_fire   = 1'b0;
    set_all_b  = 1'b0;
    frame_ok   = 1'b0;
    type_ok    = hdr_r[relay_switch_pkg::TYPE_BIT] == out_type_i;
    if (pos_r != relay_switch_pkg::BYTE_HDR) begin
      gap_nxt = gap_r + 1'b1;
    end
    if (rx_err || (pos_r != relay_switch_pkg::BYTE_HDR && gap_r == GAP_MAX)) begin
      // Broken or stalled frame is thrown away, relays untouched
      pos_nxt  = relay_switch_pkg::BYTE_HDR;
      gap_nxt  = '0;
      drop_nxt = 1'b1;
    end else if (rx_valid) begin
      gap_nxt = '0;
      unique case (pos_r)
        relay_switch_pkg::BYTE_HDR: begin
          hdr_nxt = rx_data;
          pos_nxt = relay_switch_pkg::BYTE_ARG;
        end
        relay_switch_pkg::BYTE_ARG: begin
          arg_nxt = rx_data;
          pos_nxt = relay_switch_pkg::BYTE_CHK;
        end
        default: begin
          pos_nxt  = relay_switch_pkg::BYTE_HDR;
          frame_ok = (rx_data == (hdr_r ^ arg_r ^ relay_switch_pkg::CHK_SEED))
                     && hdr_r[relay_switch_pkg::RSV_MSB:0] == relay_switch_pkg::RSV_VAL;
          if (!frame_ok) begin
            drop_nxt = 1'b1;
          end else if (op == relay_switch_pkg::OP_QUERY) begin
            // Reply only when address and type both match
            query_hit = type_ok && arg_r == {4'h0, addr_sw_i};
          end else if (op != relay_switch_pkg::OP_SET) begin
            drop_nxt = 1'b1;
          end else if (arg_r == relay_switch_pkg::CHAN_ALL_B) begin
            // Minus one is legal only for busbar B of an output unit
            if (!hdr_r[relay_switch_pkg::TYPE_BIT] || !is_b) begin
              drop_nxt = 1'b1;
            end else if (type_ok) begin
              set_fire  = 1'b1;
              set_all_b = 1'b1;
              rly_b_nxt = ~chan_hot(chan_a_r, addr_sw_i);
            end
          end else if (arg_r > relay_switch_pkg::CHAN_MAX) begin
            drop_nxt = 1'b1;
          end else if (type_ok) begin
            // Own range closes one relay; zero or foreign channel opens all of that busbar
            set_fire = 1'b1;
            if (is_b) begin
              rly_b_nxt = chan_hot(arg_r, addr_sw_i);
            end else begin
              rly_a_nxt  = chan_hot(arg_r, addr_sw_i);
              chan_a_nxt = arg_r;
            end
          end
        end
      endcase
    end
  end

  // Parser and relay registers; reset opens every relay
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_r      <= relay_switch_pkg::BYTE_HDR;
      hdr_r      <= 8'h00;
      arg_r      <= 8'h00;
      gap_r      <= '0;
      rly_a_r    <= 8'h00;
      rly_b_r    <= 8'h00;
      chan_a_r   <= relay_switch_pkg::CHAN_NONE;
      cmd_drop_o <= 1'b0;
    end else begin
      pos_r      <= pos_nxt;
      hdr_r      <= hdr_nxt;
      arg_r      <= arg_nxt;
      gap_r      <= gap_nxt;
      rly_a_r    <= rly_a_nxt;
      rly_b_r    <= rly_b_nxt;
      chan_a_r   <= chan_a_nxt;
      cmd_drop_o <= drop_nxt;
    end
  end

  // Power indicator and pass-through; the copy is one cycle late, far below a bit time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_r <= 1'b0;
      fwd_r   <= 1'b1;
    end else begin
      ready_r <= 1'b1;
      fwd_r   <= up_rx_i;
    end
  end

  // Indicators mirror the relays
  assign relay_a_o    = rly_a_r;
  assign relay_b_o    = rly_b_r;
  assign led_chan_a_o = rly_a_r;
  assign led_chan_b_o = rly_b_r;
  assign led_bus_a_o  = |rly_a_r;
  assign led_bus_b_o  = |rly_b_r;
  assign led_power_o  = ready_r;
  assign down_tx_o    = fwd_r;

  // Response transmitter state
  tx_st_t         tx_st_r, tx_st_nxt;
  logic [TCW-1:0] tcnt_r, tcnt_nxt;
  logic [2:0]     tbit_r, tbit_nxt;
  logic [1:0]     tbyte_r, tbyte_nxt;
  logic [7:0]     tsh_r, tsh_nxt;
  logic           line_nxt, reply_r;
  logic [7:0]     resp_byte;

  // Response string: tag, firmware, hardware, terminator
  always_comb begin
    unique case (tbyte_nxt)
      2'h0:    resp_byte = relay_switch_pkg::RESP_TAG;
      2'h1:    resp_byte = FW_VERSION;
      2'h2:    resp_byte = HW_STATUS;
      default: resp_byte = relay_switch_pkg::RESP_END;
    endcase
  end

  // Transmitter next state; a query that arrives mid-reply is ignored
  always_comb begin
    tx_st_nxt = tx_st_r;
    tcnt_nxt  = tcnt_r + 1'b1;
    tbit_nxt  = tbit_r;
    tbyte_nxt = tbyte_r;
    tsh_nxt   = tsh_r;
    unique case (tx_st_r)
      TX_IDLE: begin
        tcnt_nxt = '0;
        if (query_hit) begin
          tx_st_nxt = TX_START;
          tbyte_nxt = 2'h0;
        end
      end
      TX_START: begin
        if (tcnt_r == TX_FULL) begin
          tcnt_nxt  = '0;
          tbit_nxt  = 3'h0;
          tsh_nxt   = resp_byte;
          tx_st_nxt = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tcnt_r == TX_FULL) begin
          tcnt_nxt = '0;
          tsh_nxt  = {1'b1, tsh_r[7:1]};
          tbit_nxt = tbit_r + 1'b1;
          if (tbit_r == 3'h7) begin
            tx_st_nxt = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (tcnt_r == TX_FULL) begin
          tcnt_nxt  = '0;
          tbyte_nxt = tbyte_r + 1'b1;
          tx_st_nxt = (tbyte_r == RESP_LAST) ? TX_IDLE : TX_START;
        end
      end
    endcase
    // Own line idles high so it can be ANDed with the downstream replies
    unique case (tx_st_r)
      TX_START: line_nxt = 1'b0;
      TX_DATA:  line_nxt = tsh_r[0];
      default:  line_nxt = 1'b1;
    endcase
  end

  // Transmitter registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st_r <= TX_IDLE;
      tcnt_r  <= '0;
      tbit_r  <= 3'h0;
      tbyte_r <= 2'h0;
      tsh_r   <= 8'hFF;
      reply_r <= 1'b1;
    end else begin
      tx_st_r <= tx_st_nxt;
      tcnt_r  <= tcnt_nxt;
      tbit_r  <= tbit_nxt;
      tbyte_r <= tbyte_nxt;
      tsh_r   <= tsh_nxt;
      reply_r <= line_nxt & down_reply_i;
    end
  end

  assign up_reply_o = reply_r;

  a_power_on_led: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |=> led_power_o[*4]) else $error("power indicator not lit after reset");
  a_bus_led_sum: assert property (@(posedge clk_i) disable iff (rst_i)
    led_bus_b_o == (relay_b_o != 8'h00) && led_bus_a_o == (led_chan_a_o != 8'h00))
    else $error("busbar indicator disagrees with channels");
  a_single_chan: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot0(relay_a_o) and (set_fire && is_b && !set_all_b |=> $onehot0(relay_b_o)))
    else $error("more than one channel closed");
  a_zero_opens: assert property (@(posedge clk_i) disable iff (rst_i)
    set_fire && arg_r == 8'h00 |=> (is_b ? relay_b_o : relay_a_o) == 8'h00)
    else $error("channel zero left a relay closed");
  a_all_b_close: assert property (@(posedge clk_i) disable iff (rst_i)
    set_all_b |=> $countones(relay_b_o) >= 7 && (relay_b_o & relay_a_o) == 8'h00)
    else $error("minus one did not close busbar B");
  a_quiet_reply: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_st_r == TX_IDLE && !query_hit |=> tx_st_r == TX_IDLE)
    else $error("transmit without a query");
  a_query_start: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_st_r == TX_IDLE && query_hit |-> ##2 !up_reply_o)
    else $error("query answer start bit missing");
  a_forward_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> down_tx_o == $past(up_rx_i)) else $error("upstream bit not forwarded");
  a_drop_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_drop_o |-> $stable(relay_a_o) && $stable(relay_b_o))
    else $error("dropped command changed relays");
  a_relays_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !set_fire |=> $stable(relay_a_o) && $stable(relay_b_o))
    else $error("relays changed without a command");
endmodule
`default_nettype wire

// file: pkg/relay_switch_pkg.sv
// Shared constants for the cascaded relay switch command handler
package relay_switch_pkg;
  // Serial link, fixed 8N1
  localparam int BAUD_RATE  = 19200;
  localparam int CLK_HZ     = 250_000_000;
  localparam int DATA_BITS  = 8;
  localparam int GAP_BITS   = 30;              // Idle bit times that abort a half-received command
  // Unit geometry
  localparam int CH_PER_UNIT = 8;
  localparam int ADDR_W      = 4;
  localparam int BASE_SHIFT  = 3;               // Channel base is address times eight
  // Command header layout
  localparam int OP_MSB   = 7;
  localparam int OP_LSB   = 4;
  localparam int TYPE_BIT = 3;                  // 0 input switcher, 1 output switcher
  localparam int BUS_BIT  = 2;                  // 0 busbar A, 1 busbar B
  localparam int RSV_MSB  = 1;
  localparam logic [3:0] OP_QUERY = 4'h5;
  localparam logic [3:0] OP_SET   = 4'h6;
  localparam logic [1:0] RSV_VAL  = 2'h0;
  localparam logic [7:0] CHK_SEED = 8'h5A;
  // Channel codes
  localparam logic [7:0] CHAN_NONE  = 8'h00;
  localparam logic [7:0] CHAN_MAX   = 8'h80;   // 128
  localparam logic [7:0] CHAN_ALL_B = 8'hFF;   // Minus one
  // Query response string
  localparam int         RESP_LEN = 4;
  localparam logic [7:0] RESP_TAG = 8'h55;
  localparam logic [7:0] RESP_END = 8'h0D;
  localparam logic [1:0] BYTE_HDR = 2'h0;
  localparam logic [1:0] BYTE_ARG = 2'h1;
  localparam logic [1:0] BYTE_CHK = 2'h2;
endpackage

// file: core/serial_byte_rx.sv
// Asynchronous 8N1 byte receiver with framing error report
`timescale 1ns/1ns
`default_nettype none
module serial_byte_rx #(
  parameter int BIT_CYCLES = 13020
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       rx_i,
  output logic [7:0]      data_o,
  output logic            valid_o,
  output logic            err_o
);
  localparam int CNT_W = $clog2(BIT_CYCLES) + 1;
  localparam logic [CNT_W-1:0] HALF = CNT_W'(BIT_CYCLES / 2);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(BIT_CYCLES - 1);
  localparam logic [2:0]       LAST = 3'(relay_switch_pkg::DATA_BITS - 1);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_st_t;

  rx_st_t           st_r, st_nxt;     // Receiver phase
  logic [CNT_W-1:0] cnt_r, cnt_nxt;   // Cycles within the bit
  logic [2:0]       bit_r, bit_nxt;   // Data bit index
  logic [7:0]       sh_r, sh_nxt;     // Shift register, LSB first
  logic             val_nxt, err_nxt;

  // Next state: sample each bit at its middle
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r + 1'b1;
    bit_nxt = bit_r;
    sh_nxt  = sh_r;
    val_nxt = 1'b0;
    err_nxt = 1'b0;
    unique case (st_r)
      RX_IDLE: begin
        cnt_nxt = '0;
        if (!rx_i) begin
          st_nxt = RX_START;
        end
      end
      RX_START: begin
        // A start bit gone by mid-bit is line noise
        if (cnt_r == HALF) begin
          cnt_nxt = '0;
          bit_nxt = '0;
          st_nxt  = rx_i ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (cnt_r == FULL) begin
          cnt_nxt = '0;
          sh_nxt  = {rx_i, sh_r[7:1]};
          bit_nxt = bit_r + 1'b1;
          if (bit_r == LAST) begin
            st_nxt = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (cnt_r == FULL) begin
          val_nxt = rx_i;
          err_nxt = !rx_i;
          st_nxt  = RX_IDLE;
        end
      end
    endcase
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r    <= RX_IDLE;
      cnt_r   <= '0;
      bit_r   <= '0;
      sh_r    <= 8'h00;
      valid_o <= 1'b0;
      err_o   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      bit_r   <= bit_nxt;
      sh_r    <= sh_nxt;
      valid_o <= val_nxt;
      err_o   <= err_nxt;
    end
  end

  assign data_o = sh_r;

  a_rx_stop_frame: assert property (@(posedge clk_i) disable iff (rst_i)
    !(valid_o && err_o)) else $error("byte both valid and in error");
endmodule
`default_nettype wire

// file: verif/controller_model.sv
// Behavioural model of the controlling analyzer on the serial command link
`timescale 1ns/1ns
`default_nettype none
module controller_model #(
  parameter int BIT = 16
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic reply_i,  // Replies coming back up the chain
  output logic      line_o    // Command line, idle high
);
  logic [7:0] rx_q[$];        // Reply bytes in arrival order
  logic [7:0] rx_b;           // Reply byte under assembly

  // Line idles high before the first frame
  initial line_o = 1'b1;

  // One 8N1 byte, LSB first, every bit held one full bit time
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_o <= f[i];
      repeat (BIT) @(posedge clk_i);
    end
  endtask

  // Header, argument, checksum; a nonzero flip spoils the checksum on purpose
  task automatic send_frame(input logic [7:0] hdr, input logic [7:0] arg, input logic [7:0] flip);
    send_byte(hdr);
    send_byte(arg);
    send_byte(hdr ^ arg ^ relay_switch_pkg::CHK_SEED ^ flip);
  endtask

  // Reply receiver, samples each bit near its middle
  always begin
    @(posedge clk_i);
    if (rst_i === 1'b0 && reply_i === 1'b0) begin
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk_i);
        rx_b[i] = reply_i;
      end
      // Skip the stop bit before hunting the next start
      repeat (BIT) @(posedge clk_i);
      rx_q.push_back(rx_b);
    end
  end
endmodule
`default_nettype wire

// file: verif/cascaded_relay_switch_control_tb_top.sv
// Self-checking testbench of one cascaded relay switch unit
`timescale 1ns/1ns
`default_nettype none
module cascaded_relay_switch_control_tb_top;
  localparam int         BIT   = 16;     // Short bit time keeps the run brief
  localparam logic [7:0] FW    = 8'hA1;  // Arbitrary value
  localparam logic [7:0] HW    = 8'hB2;  // Arbitrary value
  localparam int         LIMIT = 60000;  // Scan plus sets need about 25000 cycles

  logic       clk_i;
  logic       rst_i        = 1'b1;
  logic [3:0] addr_sw_i    = 4'h3;       // Channels 25 to 32
  logic       out_type_i   = 1'b0;
  logic       down_reply_i = 1'b1;       // No next unit
  logic       up_rx_i;
  logic       down_tx_o;
  logic       up_reply_o;
  logic [7:0] relay_a_o;
  logic [7:0] relay_b_o;
  logic [7:0] led_chan_a_o;
  logic [7:0] led_chan_b_o;
  logic       led_bus_a_o;
  logic       led_bus_b_o;
  logic       led_power_o;
  logic       cmd_drop_o;
  logic       drop_seen    = 1'b0;       // Sticky copy of the one-cycle drop pulse
  logic       prev_rx      = 1'b1;
  logic       rst_d        = 1'b1;
  int         error_cnt    = 0;
  int         n_tests      = 0;
  int         cyc_cnt      = 0;

  relay_switch_ctrl #(.BIT_CYCLES(BIT), .GAP_CYCLES(BIT * 30), .FW_VERSION(FW), .HW_STATUS(HW)) i_relay_switch_ctrl (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .addr_sw_i    (addr_sw_i),
    .out_type_i   (out_type_i),
    .up_rx_i      (up_rx_i),
    .down_tx_o    (down_tx_o),
    .down_reply_i (down_reply_i),
    .up_reply_o   (up_reply_o),
    .relay_a_o    (relay_a_o),
    .relay_b_o    (relay_b_o),
    .led_chan_a_o (led_chan_a_o),
    .led_chan_b_o (led_chan_b_o),
    .led_bus_a_o  (led_bus_a_o),
    .led_bus_b_o  (led_bus_b_o),
    .led_power_o  (led_power_o),
    .cmd_drop_o   (cmd_drop_o)
  );

  controller_model #(.BIT(BIT)) i_controller_model (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .reply_i (up_reply_o),
    .line_o  (up_rx_i)
  );

  // Free-running 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Verdict and end of run
  task automatic report_and_stop;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Single comparison point
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One channel-setting frame, then relays, indicators and drop flag
  task automatic do_set(input logic t, input logic bus, input logic [7:0] ch, input logic [7:0] flip,
                        input logic [7:0] ea, input logic [7:0] eb, input logic ed);
    drop_seen = 1'b0;
    i_controller_model.send_frame({relay_switch_pkg::OP_SET, t, bus, 2'h0}, ch, flip);
    repeat (4) @(posedge clk_i);
    check(relay_a_o, ea);
    check(relay_b_o, eb);
    check(led_chan_a_o, ea);
    check(led_chan_b_o, eb);
    check({6'h0, led_bus_b_o, led_bus_a_o}, {6'h0, |eb, |ea});
    check({7'h0, drop_seen}, {7'h0, ed});
  endtask

  // Monitors: drop pulse latch and one-clock pass-through of the command line
  always @(posedge clk_i) begin
    if (cmd_drop_o === 1'b1) begin
      drop_seen <= 1'b1;
    end
    if (rst_d === 1'b0) begin
      check({7'h0, down_tx_o}, {7'h0, prev_rx});
    end
    prev_rx <= up_rx_i;
    rst_d   <= rst_i;
  end

  // Hang guard
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == LIMIT) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check({7'h0, led_power_o}, 8'h01);
    check(relay_a_o | relay_b_o, 8'h00);
    check({6'h0, led_bus_b_o, led_bus_a_o}, 8'h00);
    // Link scan, input type then output type at every address
    for (int a = 0; a < 16; a++) begin
      for (int t = 0; t < 2; t++) begin
        i_controller_model.send_frame({relay_switch_pkg::OP_QUERY, t[0], 1'b0, 2'h0}, {4'h0, a[3:0]}, 8'h00);
      end
    end
    repeat (800) @(posedge clk_i);
    // Only the input unit at address 3 answers
    check(8'(i_controller_model.rx_q.size()), 8'h04);
    check(i_controller_model.rx_q[0], relay_switch_pkg::RESP_TAG);
    check(i_controller_model.rx_q[1], FW);
    check(i_controller_model.rx_q[2], HW);
    check(i_controller_model.rx_q[3], relay_switch_pkg::RESP_END);
    i_controller_model.rx_q.delete();
    // Default state after activation: every line at channel zero
    do_set(1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    // Input unit, channels 25 to 32; a frame of the other type is ignored without a drop
    do_set(1'b0, 1'b0, 8'h1D, 8'h00, 8'h10, 8'h00, 1'b0);
    do_set(1'b1, 1'b0, 8'h1A, 8'h00, 8'h10, 8'h00, 1'b0);
    // Busbar B is set on its own channel, apart from A: channel 28 gives 08
    do_set(1'b0, 1'b1, 8'h1C, 8'h00, 8'h10, 8'h08, 1'b0);
    do_set(1'b0, 1'b1, 8'h19, 8'h00, 8'h10, 8'h01, 1'b0);
    do_set(1'b0, 1'b1, 8'h20, 8'h00, 8'h10, 8'h80, 1'b0);
    do_set(1'b0, 1'b0, 8'h1B, 8'hFF, 8'h10, 8'h80, 1'b1);
    do_set(1'b0, 1'b0, 8'h18, 8'h00, 8'h00, 8'h80, 1'b0);
    do_set(1'b0, 1'b1, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    do_set(1'b0, 1'b0, 8'h81, 8'h00, 8'h00, 8'h00, 1'b1);
    // Frame cut after its argument: silence must discard it untouched
    drop_seen = 1'b0;
    i_controller_model.send_byte({relay_switch_pkg::OP_SET, 4'h0});
    i_controller_model.send_byte(8'h1A);
    repeat (BIT * 32) @(posedge clk_i);
    check({7'h0, drop_seen}, 8'h01);
    check(relay_a_o, 8'h00);
    // Same unit strapped as output type at the top address, channels 121 to 128
    out_type_i <= 1'b1;
    addr_sw_i  <= 4'hF;
    @(posedge clk_i);
    do_set(1'b1, 1'b0, 8'h7B, 8'h00, 8'h04, 8'h00, 1'b0);
    do_set(1'b1, 1'b1, 8'hFF, 8'h00, 8'h04, 8'hFB, 1'b0);
    do_set(1'b0, 1'b1, 8'hFF, 8'h00, 8'h04, 8'hFB, 1'b1);
    do_set(1'b1, 1'b0, 8'h00, 8'h00, 8'h00, 8'hFB, 1'b0);
    do_set(1'b1, 1'b1, 8'hFF, 8'h00, 8'h00, 8'hFF, 1'b0);
    do_set(1'b1, 1'b1, 8'h80, 8'h00, 8'h00, 8'h80, 1'b0);
    do_set(1'b1, 1'b0, 8'hFF, 8'h00, 8'h00, 8'h80, 1'b1);
    // Setting commands never draw a reply
    check(8'(i_controller_model.rx_q.size()), 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
